/* core/ufbc_map.svh */
// register offsets, field positions, reset values and masks for the flow/baud control block
// assumes an apb slave with 32-bit words; offsets are byte addresses
// Function
// - receiver disable stops new reception at once
// - character in progress still completes into fifo
// - nine-bit bit selects 8-bit or multidrop
// - divisor is high:low plus fraction/16
// - fraction register writable only when enhanced enabled
// - sampling select gives 16x, 8x, 4x
// - dual mode treats characters as sequential pair
// - bits 3:2 select transmit flow characters
// - bits 1:0 select receive comparison characters
// - mixed modes accept either, else require both
// - enhanced bits writable only while enable set
// - reset clears protected enhanced bits, except tcr which resets to 0x0F
// - special detect compares halt two, flags match
// - second-pair special match skips fifo, interrupts
// - auto request deasserts at halt, reasserts below resume
// - auto request needs pin asserted first, else gpo
// - auto clear stops transmit while clear high
// - power-up divisor 0x0001, fraction 0x00
// - divisor, scratch, flow chars reset only at power-up
// - modem status low clears, high shows inverted inputs
// - levels are four-bit threshold times four
`ifndef UFBC_MAP_SVH
`define UFBC_MAP_SVH
`define UFBC_A_EXTRA 12'h000
`define UFBC_A_DIVLO 12'h004
`define UFBC_A_DIVHI 12'h008
`define UFBC_A_FRAC 12'h00C
`define UFBC_A_ENH 12'h010
`define UFBC_A_RES1 12'h014
`define UFBC_A_RES2 12'h018
`define UFBC_A_HALT1 12'h01C
`define UFBC_A_HALT2 12'h020
`define UFBC_A_IER 12'h024
`define UFBC_A_ISR 12'h028
`define UFBC_A_FCR 12'h02C
`define UFBC_A_MCR 12'h030
`define UFBC_A_TCR 12'h034
`define UFBC_A_TLR 12'h038
`define UFBC_A_MSR 12'h03C
`define UFBC_A_SPR 12'h040
`define UFBC_A_STAT 12'h044
`define UFBC_B_RXDIS 1
`define UFBC_B_NINE 0
`define UFBC_B_ENH 4
`define UFBC_B_SPEC 5
`define UFBC_B_ARTS 6
`define UFBC_B_ACTS 7
`define UFBC_B_MCR_RTS 1
`define UFBC_R_DIVLO 8'h01
`define UFBC_R_DIVHI 8'h00
`define UFBC_R_SPR 8'hFF
`define UFBC_R_TCR 8'h0F
`define UFBC_M_IER 8'hF0
`define UFBC_M_ISR 8'h30
`define UFBC_M_FCR 8'h30
`define UFBC_M_MCR 8'hE4
`define UFBC_M_FRAC 8'h3F
`define UFBC_LVL_MUL 4
`endif

/* core/ufbc_pkg.sv */
// types for the flow/baud control block
// assumes nothing beyond a systemverilog compiler
package ufbc_pkg;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic done;
    } ufbc_rx_t;
    typedef enum logic [1:0] {
        UFBC_OS16,
        UFBC_OS8,
        UFBC_OS4
    } ufbc_os_t;
    typedef enum {
        UFBC_IDLE,
        UFBC_GOT_FIRST
    } ufbc_pair_t;
endpackage

/* core/ufbc_core.sv */
// flow control, baud generation and enhanced register gate
// assumes apb master, fifo level and receive character stream from neighbouring blocks
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "ufbc_map.svh"
module ufbc_core #(
    parameter int LVL_W = 7
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic por_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ufbc_pkg::ufbc_rx_t rx_char,
    input wire logic [LVL_W-1:0] rx_level,
    input wire logic clear_in_n,
    input wire logic [3:0] modem_in_n,
    output logic rx_accept,
    output logic fifo_wr,
    output logic [7:0] fifo_data,
    output logic halt_seen,
    output logic resume_seen,
    output logic special_seen,
    output logic tx_allow,
    output logic request_out_n,
    output logic nine_bit_mode,
    output logic sample_tick,
    output logic [1:0] tx_flow_sel
);
    // ****************************************
    // registers
    // ****************************************
    logic [7:0] extra_ff, divlo_ff, divhi_ff, frac_ff, enh_ff;
    logic [7:0] res1_ff, res2_ff, halt1_ff, halt2_ff;
    logic [7:0] ier_ff, isr_ff, fcr_ff, mcr_ff, tcr_ff, tlr_ff, msr_ff, spr_ff;
    logic [7:0] wd;
    logic wr, rd, en;
    assign wd = pwdata[7:0];
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign en = enh_ff[`UFBC_B_ENH];
    // protected bits keep old value unless enhanced enable is set
    function automatic logic [7:0] gate(input logic [7:0] old, input logic [7:0] nv,
                                        input logic [7:0] m, input logic e);
        gate = e ? nv : ((old & m) | (nv & ~m));
    endfunction
    wire hit_extra = wr && paddr == `UFBC_A_EXTRA;
    wire hit_divlo = wr && paddr == `UFBC_A_DIVLO;
    wire hit_divhi = wr && paddr == `UFBC_A_DIVHI;
    wire hit_frac = wr && paddr == `UFBC_A_FRAC && en;
    wire hit_enh = wr && paddr == `UFBC_A_ENH;
    wire hit_res1 = wr && paddr == `UFBC_A_RES1;
    wire hit_res2 = wr && paddr == `UFBC_A_RES2;
    wire hit_halt1 = wr && paddr == `UFBC_A_HALT1;
    wire hit_halt2 = wr && paddr == `UFBC_A_HALT2;
    wire hit_ier = wr && paddr == `UFBC_A_IER;
    wire hit_isr = wr && paddr == `UFBC_A_ISR;
    wire hit_fcr = wr && paddr == `UFBC_A_FCR;
    wire hit_mcr = wr && paddr == `UFBC_A_MCR;
    wire hit_tcr = wr && paddr == `UFBC_A_TCR && en;
    wire hit_tlr = wr && paddr == `UFBC_A_TLR && en;
    wire hit_spr = wr && paddr == `UFBC_A_SPR;
    // ****************************************
    // power-up only registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!por_n) begin
            divlo_ff <= `UFBC_R_DIVLO;
            divhi_ff <= `UFBC_R_DIVHI;
            spr_ff <= `UFBC_R_SPR;
            res1_ff <= 8'h00;
            res2_ff <= 8'h00;
            halt1_ff <= 8'h00;
            halt2_ff <= 8'h00;
        end else begin
            if (hit_divlo) divlo_ff <= wd;
            if (hit_divhi) divhi_ff <= wd;
            if (hit_spr) spr_ff <= wd;
            if (hit_res1) res1_ff <= wd;
            if (hit_res2) res2_ff <= wd;
            if (hit_halt1) halt1_ff <= wd;
            if (hit_halt2) halt2_ff <= wd;
        end
    end
    // ****************************************
    // reset registers
    // ****************************************
    logic spec_evt, halt_evt;
    always_ff @(posedge clk) begin
        if (!rstn || !por_n) begin
            extra_ff <= 8'h00;
            frac_ff <= 8'h00;
            enh_ff <= 8'h00;
            ier_ff <= 8'h00;
            isr_ff <= 8'h00;
            fcr_ff <= 8'h00;
            mcr_ff <= 8'h00;
            tcr_ff <= `UFBC_R_TCR;
            tlr_ff <= 8'h00;
        end else begin
            if (hit_extra) extra_ff <= wd;
            if (hit_frac) frac_ff <= wd & `UFBC_M_FRAC;
            if (hit_enh) enh_ff <= wd;
            if (hit_ier) ier_ff <= gate(ier_ff, wd, `UFBC_M_IER, en);
            if (hit_fcr) fcr_ff <= gate(fcr_ff, wd, `UFBC_M_FCR, en);
            if (hit_mcr) mcr_ff <= gate(mcr_ff, wd, `UFBC_M_MCR, en);
            if (hit_tcr) tcr_ff <= wd;
            if (hit_tlr) tlr_ff <= wd;
            // set wins over a software clear in the same cycle
            isr_ff[4] <= spec_evt | (hit_isr ? (en ? wd[4] : isr_ff[4]) : isr_ff[4]);
            isr_ff[5] <= halt_evt | (hit_isr ? (en ? wd[5] : isr_ff[5]) : isr_ff[5]);
        end
    end
    // low nibble cleared, high nibble tracks inverted inputs
    always_ff @(posedge clk) begin
        if (!rstn) msr_ff <= {~modem_in_n, 4'h0};
        else msr_ff <= {~modem_in_n, msr_ff[3:0]};
    end
    // ****************************************
    // apb slave, zero wait
    // ****************************************
    logic [7:0] rsel;
    always_comb begin
        case (paddr)
            `UFBC_A_EXTRA: rsel = extra_ff;
            `UFBC_A_DIVLO: rsel = divlo_ff;
            `UFBC_A_DIVHI: rsel = divhi_ff;
            `UFBC_A_FRAC: rsel = frac_ff;
            `UFBC_A_ENH: rsel = enh_ff;
            `UFBC_A_RES1: rsel = res1_ff;
            `UFBC_A_RES2: rsel = res2_ff;
            `UFBC_A_HALT1: rsel = halt1_ff;
            `UFBC_A_HALT2: rsel = halt2_ff;
            `UFBC_A_IER: rsel = ier_ff;
            `UFBC_A_ISR: rsel = isr_ff;
            `UFBC_A_FCR: rsel = fcr_ff;
            `UFBC_A_MCR: rsel = mcr_ff;
            `UFBC_A_TCR: rsel = tcr_ff;
            `UFBC_A_TLR: rsel = tlr_ff;
            `UFBC_A_MSR: rsel = msr_ff;
            `UFBC_A_SPR: rsel = spr_ff;
            `UFBC_A_STAT: rsel = {6'h00, ~request_out_n, tx_allow};
            default: rsel = 8'h00;
        endcase
    end
    wire known = paddr <= `UFBC_A_STAT && paddr[1:0] == 2'b00;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~known;
            prdata <= (psel & ~penable & ~pwrite) ? {24'h00_0000, rsel} : 32'h0000_0000;
        end
    end
    // ****************************************
    // receive path: disable, compare, special
    // ****************************************
    logic busy_ff;
    // a character whose start was seen before disable still lands
    always_ff @(posedge clk) begin
        if (!rstn) busy_ff <= 1'b0;
        else if (rx_char.done) busy_ff <= 1'b0;
        else if (rx_char.valid && !extra_ff[`UFBC_B_RXDIS]) busy_ff <= 1'b1;
    end
    wire [1:0] rxsel = enh_ff[1:0];
    wire [1:0] txsel = enh_ff[3:2];
    wire c = rx_char.done & busy_ff;
    wire [7:0] d = rx_char.data;
    wire either = rxsel == 2'b11 && (txsel == 2'b10 || txsel == 2'b01);
    wire pair = rxsel == 2'b11 && !either;
    ufbc_pkg::ufbc_pair_t hst_ff, rst_ff;
    wire h1 = d == halt1_ff;
    wire h2 = d == halt2_ff;
    wire r1 = d == res1_ff;
    wire r2 = d == res2_ff;
    logic hmatch, rmatch;
    always_comb begin
        case (rxsel)
            2'b10: begin
                hmatch = h1;
                rmatch = r1;
            end
            2'b01: begin
                hmatch = h2;
                rmatch = r2;
            end
            2'b11: begin
                hmatch = either ? (h1 | h2) : (hst_ff == ufbc_pkg::UFBC_GOT_FIRST && h2);
                rmatch = either ? (r1 | r2) : (rst_ff == ufbc_pkg::UFBC_GOT_FIRST && r2);
            end
            default: begin
                hmatch = 1'b0;
                rmatch = 1'b0;
            end
        endcase
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hst_ff <= ufbc_pkg::UFBC_IDLE;
            rst_ff <= ufbc_pkg::UFBC_IDLE;
        end else if (c) begin
            hst_ff <= (pair && h1) ? ufbc_pkg::UFBC_GOT_FIRST : ufbc_pkg::UFBC_IDLE;
            rst_ff <= (pair && r1) ? ufbc_pkg::UFBC_GOT_FIRST : ufbc_pkg::UFBC_IDLE;
        end
    end
    wire spec = c && enh_ff[`UFBC_B_SPEC] && h2;
    wire drop = spec && rxsel == 2'b01;
    assign spec_evt = spec;
    assign halt_evt = drop && ier_ff[5];
    logic stopped_ff;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fifo_wr <= 1'b0;
            fifo_data <= 8'h00;
            halt_seen <= 1'b0;
            resume_seen <= 1'b0;
            special_seen <= 1'b0;
            rx_accept <= 1'b0;
            nine_bit_mode <= 1'b0;
            tx_flow_sel <= 2'b00;
            stopped_ff <= 1'b0;
        end else begin
            fifo_wr <= c & ~drop;
            fifo_data <= d;
            halt_seen <= c & hmatch;
            resume_seen <= c & rmatch;
            special_seen <= spec & (ier_ff[5] | ~drop);
            rx_accept <= ~extra_ff[`UFBC_B_RXDIS];
            nine_bit_mode <= extra_ff[`UFBC_B_NINE];
            tx_flow_sel <= txsel;
            if (c & hmatch) stopped_ff <= 1'b1;
            else if (c & rmatch) stopped_ff <= 1'b0;
        end
    end
    // ****************************************
    // hardware flow control
    // ****************************************
    wire [LVL_W-1:0] halt_lvl = LVL_W'(tcr_ff[3:0] * `UFBC_LVL_MUL);
    wire [LVL_W-1:0] res_lvl = LVL_W'(tcr_ff[7:4] * `UFBC_LVL_MUL);
    logic armed_ff, rts_hi_ff;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            armed_ff <= 1'b0;
            rts_hi_ff <= 1'b0;
            request_out_n <= 1'b1;
            tx_allow <= 1'b0;
        end else begin
            if (mcr_ff[`UFBC_B_MCR_RTS]) armed_ff <= 1'b1;
            else armed_ff <= 1'b0;
            if (rx_level >= halt_lvl) rts_hi_ff <= 1'b1;
            else if (rx_level < res_lvl) rts_hi_ff <= 1'b0;
            if (enh_ff[`UFBC_B_ARTS] && armed_ff) request_out_n <= rts_hi_ff;
            else request_out_n <= ~mcr_ff[`UFBC_B_MCR_RTS];
            tx_allow <= ~(enh_ff[`UFBC_B_ACTS] & clear_in_n) & ~stopped_ff;
        end
    end
    // ****************************************
    // fractional baud generator
    // ****************************************
    // one tick per oversample; each takes int or int+1 reference cycles
    // the rate select only sets how many ticks make a bit, downstream
    wire [15:0] divi = {divhi_ff, divlo_ff};
    logic [19:0] cnt_ff;
    logic [3:0] acc_ff;
    wire [19:0] base = {4'h0, divi};
    wire [4:0] sum = {1'b0, acc_ff} + {1'b0, frac_ff[3:0]};
    wire [19:0] per = base + {19'h0_0000, sum[4]};
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_ff <= 20'h0_0001;
            acc_ff <= 4'h0;
            sample_tick <= 1'b0;
        end else if (cnt_ff <= 20'h0_0001) begin
            cnt_ff <= (per == 20'h0_0000) ? 20'h0_0001 : per;
            acc_ff <= sum[3:0];
            sample_tick <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff - 20'h0_0001;
            sample_tick <= 1'b0;
        end
    end
endmodule

/* dv/ufbc_rx_src.sv */
// remote receive source: hands one character per request to ufbc_core
// assumes the rx_char carrier of ufbc_pkg and a bench that pulses go
`timescale 1ns/1ns
module ufbc_rx_src (
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] char_in,
    input wire logic [7:0] len,
    output ufbc_pkg::ufbc_rx_t rx_char,
    output logic busy
);
    logic [7:0] cnt_ff = 8'h00;
    logic [7:0] dat_ff = 8'h00;
    wire last = cnt_ff == 8'h01;
    always @(posedge clk) begin
        if (go && !busy) begin
            cnt_ff <= len;
            dat_ff <= char_in;
        end else if (busy) begin
            cnt_ff <= cnt_ff - 8'h01;
        end
    end
    assign busy = cnt_ff != 8'h00;
    // inverted byte outside the done cycle, so stale data can never match
    assign rx_char = {busy, last ? dat_ff : ~dat_ff, last};
endmodule

/* dv/ufbc_core_chk.sv */
// assertion checker for ufbc_core, bound at the foot of this file
// assumes writes land at the apb access edge and one-cycle receive latency
`timescale 1ns/1ns
`include "ufbc_map.svh"
module ufbc_core_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic por_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire ufbc_pkg::ufbc_rx_t rx_char,
    input wire logic clear_in_n,
    input wire logic rx_accept,
    input wire logic fifo_wr,
    input wire logic halt_seen,
    input wire logic special_seen,
    input wire logic tx_allow,
    input wire logic nine_bit_mode,
    input wire logic [1:0] tx_flow_sel
);
    // ********
    // register mirrors
    // ********
    logic [7:0] enh_ff, extra_feature_control_ff, halt2_ff;
    logic [5:0] frac_ff;
    wire wr_go = psel & penable & pwrite & pready;
    wire rd_go = psel & penable & ~pwrite & pready;
    always_ff @(posedge clk) begin
        if (!rstn || !por_n) begin
            enh_ff <= 8'h00;
            extra_feature_control_ff <= 8'h00;
            frac_ff <= 6'h00;
        end else if (wr_go) begin
            if (paddr == `UFBC_A_ENH) enh_ff <= pwdata[7:0];
            if (paddr == `UFBC_A_EXTRA) extra_feature_control_ff <= pwdata[7:0];
            if (paddr == `UFBC_A_FRAC && enh_ff[4]) frac_ff <= pwdata[5:0];
        end
    end
    // flow characters survive the pin reset
    always_ff @(posedge clk) begin
        if (!por_n) halt2_ff <= 8'h00;
        else if (wr_go && paddr == `UFBC_A_HALT2) halt2_ff <= pwdata[7:0];
    end
    // ********
    // properties
    // ********
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn || !por_n);
    sequence s_halt2_drop;
        rx_char.done && enh_ff[5] && enh_ff[1:0] == 2'b01 && rx_char.data == halt2_ff;
    endsequence
    sequence s_clear_high;
        enh_ff[7] && clear_in_n ##1 enh_ff[7] && clear_in_n;
    endsequence
    a_setup_answer: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_pready_once: assert property (pready |=> !pready)
        else $error("pready held");
    a_rx_gate: assert property (extra_feature_control_ff[1] && $past(extra_feature_control_ff[1]) |-> !rx_accept)
        else $error("receiver still accepting");
    a_nine_mode: assert property ($stable(extra_feature_control_ff[0]) |-> nine_bit_mode == extra_feature_control_ff[0])
        else $error("nine bit mode wrong");
    a_flow_sel: assert property ($stable(enh_ff) |-> tx_flow_sel == enh_ff[3:2])
        else $error("transmit flow select wrong");
    a_clear_stop: assert property (s_clear_high |=> !tx_allow)
        else $error("transmit allowed while clear high");
    a_fifo_cause: assert property (fifo_wr |-> $past(rx_char.done))
        else $error("fifo write without character");
    a_special_match: assert property (special_seen |-> $past(rx_char.data) == halt2_ff)
        else $error("special flag without match");
    a_halt_skip: assert property (s_halt2_drop |=> !fifo_wr && halt_seen)
        else $error("second halt character mishandled");
    a_frac_read: assert property (rd_go && paddr == `UFBC_A_FRAC |-> prdata[5:0] == frac_ff)
        else $error("fraction register content wrong");
endmodule
bind ufbc_core ufbc_core_chk i_ufbc_core_chk (
    .clk(clk), .rstn(rstn), .por_n(por_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .rx_char(rx_char),
    .clear_in_n(clear_in_n), .rx_accept(rx_accept), .fifo_wr(fifo_wr),
    .halt_seen(halt_seen), .special_seen(special_seen), .tx_allow(tx_allow),
    .nine_bit_mode(nine_bit_mode), .tx_flow_sel(tx_flow_sel)
);

/* dv/tb_top.sv */
// self-checking bench for ufbc_core with a receive source on its far side
// assumes the checker binds itself; one 100 MHz clock, apb master here
`timescale 1ns/1ns
`include "ufbc_map.svh"
module tb_top;
    logic clk = 1'b0, rstn = 1'b0, por_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic pready, pslverr, clear_in_n = 1'b0, rx_accept, fifo_wr, halt_seen, resume_seen;
    logic special_seen, tx_allow, request_out_n, nine_bit_mode, sample_tick, busy, rd_e;
    logic go = 1'b0, ev_clr = 1'b0;
    logic [6:0] rx_level = 7'h00;
    logic [3:0] modem_in_n = 4'h5, ev = 4'h0;
    logic [7:0] fifo_data, src_char = 8'h00, src_len = 8'h04, rd_v, cur = 8'h10;
    logic [1:0] tx_flow_sel;
    ufbc_pkg::ufbc_rx_t rx_char;
    int n_mismatch = 0, n_tests = 0, ticks = 0, i, k;
    // address, write data, read back, error
    logic [28:0] reg_rows [13] = '{{`UFBC_A_ENH, 8'h10, 8'h10, 1'b0},
        {`UFBC_A_DIVLO, 8'hA5, 8'hA5, 1'b0}, {`UFBC_A_DIVHI, 8'h3C, 8'h3C, 1'b0},
        {`UFBC_A_FRAC, 8'hFF, 8'h3F, 1'b0}, {`UFBC_A_RES1, 8'h11, 8'h11, 1'b0},
        {`UFBC_A_RES2, 8'h22, 8'h22, 1'b0}, {`UFBC_A_HALT1, 8'h33, 8'h33, 1'b0},
        {`UFBC_A_HALT2, 8'h44, 8'h44, 1'b0}, {`UFBC_A_IER, 8'hFF, 8'hFF, 1'b0},
        {`UFBC_A_TCR, 8'h24, 8'h24, 1'b0}, {`UFBC_A_SPR, 8'h5A, 8'h5A, 1'b0},
        {`UFBC_A_EXTRA, 8'h00, 8'h00, 1'b0}, {12'h048, 8'h77, 8'h00, 1'b1}};
    // after pin reset (first eight), then after power-up reset
    logic [19:0] rst_rows [14] = '{{`UFBC_A_DIVLO, 8'hA5}, {`UFBC_A_SPR, 8'h5A},
        {`UFBC_A_HALT2, 8'h44}, {`UFBC_A_FRAC, 8'h00}, {`UFBC_A_IER, 8'h00},
        {`UFBC_A_TCR, 8'h0F}, {`UFBC_A_ENH, 8'h00}, {`UFBC_A_MSR, 8'hA0},
        {`UFBC_A_DIVLO, 8'h01}, {`UFBC_A_DIVHI, 8'h00}, {`UFBC_A_SPR, 8'hFF},
        {`UFBC_A_HALT2, 8'h00}, {`UFBC_A_RES1, 8'h00}, {`UFBC_A_FRAC, 8'h00}};
    // flow setting, character, mask and expected {special, halt, resume, fifo write}
    logic [23:0] rx_rows [11] = '{{8'h12, 8'h33, 8'hE4}, {8'h12, 8'h11, 8'hE2},
        {8'h12, 8'h22, 8'hE0}, {8'h11, 8'h44, 8'hE4}, {8'h1F, 8'h33, 8'hE0},
        {8'h1F, 8'h44, 8'hE4}, {8'h1B, 8'h44, 8'hE4}, {8'h17, 8'h22, 8'hE2},
        {8'h31, 8'h44, 8'hF4}, {8'h32, 8'h44, 8'hF9}, {8'h10, 8'h33, 8'hF1}};
    logic [6:0] lvl [4] = '{7'h0F, 7'h10, 7'h09, 7'h07};
    always #5 clk = ~clk;
    always @(posedge clk) begin
        ev <= ev_clr ? 4'h0 : ev | {special_seen, halt_seen, resume_seen, fifo_wr};
        if (sample_tick) ticks <= ticks + 1;
    end
    ufbc_core i_ufbc_core (.clk(clk), .rstn(rstn), .por_n(por_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_char(rx_char), .rx_level(rx_level),
        .clear_in_n(clear_in_n), .modem_in_n(modem_in_n), .rx_accept(rx_accept),
        .fifo_wr(fifo_wr), .fifo_data(fifo_data), .halt_seen(halt_seen),
        .resume_seen(resume_seen), .special_seen(special_seen), .tx_allow(tx_allow),
        .request_out_n(request_out_n), .nine_bit_mode(nine_bit_mode),
        .sample_tick(sample_tick), .tx_flow_sel(tx_flow_sel));
    ufbc_rx_src i_ufbc_rx_src (.clk(clk), .go(go), .char_in(src_char), .len(src_len),
        .rx_char(rx_char), .busy(busy));
    // ********
    // tasks
    // ********
    task automatic test_done();
        if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int j;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        // look at pready mid-cycle, where it has settled, then finish on the edge
        @(negedge clk);
        for (j = 0; j < 20 && pready !== 1'b1; j++) @(negedge clk);
        rd_v = prdata[7:0];
        rd_e = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (j == 20) n_mismatch++;
        if (j == 20) test_done();
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd_v, e);
    endtask
    task automatic reset_dut(input logic p);
        @(posedge clk);
        rstn <= 1'b0;
        por_n <= p;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        por_n <= 1'b1;
    endtask
    task automatic start_rx(input logic [7:0] c, input logic [7:0] l);
        @(posedge clk);
        {go, ev_clr, src_char, src_len} <= {2'b11, c, l};
        @(posedge clk);
        {go, ev_clr} <= 2'b00;
    endtask
    task automatic wait_rx();
        @(posedge clk);
        for (k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clk);
        if (k == 200) n_mismatch++;
        if (k == 200) test_done();
        repeat (2) @(posedge clk);
    endtask
    task automatic tick_chk(input int lo, input int hi);
        repeat (20) @(posedge clk);
        k = ticks;
        repeat (160) @(posedge clk);
        chk((ticks - k) inside {[lo:hi]}, 1'b1);
    endtask
    // ********
    // main sequence
    // ********
    initial begin
        repeat (6) @(posedge clk);
        {rstn, por_n} <= 2'b11;
        for (i = 0; i < 13; i++) begin
            apb(1'b1, reg_rows[i][28:17], reg_rows[i][16:9]);
            rd_chk(reg_rows[i][28:17], reg_rows[i][8:1]);
            chk(rd_e, reg_rows[i][0]);
        end
        apb(1'b1, `UFBC_A_ENH, 8'h00);
        apb(1'b1, `UFBC_A_FRAC, 8'h00);
        apb(1'b1, `UFBC_A_IER, 8'h00);
        apb(1'b1, `UFBC_A_TCR, 8'h00);
        rd_chk(`UFBC_A_FRAC, 8'h3F);
        rd_chk(`UFBC_A_IER, 8'hF0);
        rd_chk(`UFBC_A_TCR, 8'h24);
        for (i = 0; i < 14; i++) begin
            if (i == 0 || i == 8) reset_dut(i == 0);
            rd_chk(rst_rows[i][19:8], rst_rows[i][7:0]);
        end
        apb(1'b1, `UFBC_A_ENH, 8'h90);
        clear_in_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk(tx_allow, 1'b0);
        clear_in_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk(tx_allow, 1'b1);
        apb(1'b1, `UFBC_A_ENH, 8'h10);
        apb(1'b1, `UFBC_A_TCR, 8'h24);
        repeat (2) @(posedge clk);
        chk(request_out_n, 1'b1);
        apb(1'b1, `UFBC_A_MCR, 8'h02);
        repeat (2) @(posedge clk);
        chk(request_out_n, 1'b0);
        apb(1'b1, `UFBC_A_ENH, 8'h50);
        for (i = 0; i < 4; i++) begin
            rx_level <= lvl[i];
            repeat (3) @(posedge clk);
            chk(request_out_n, i == 1 || i == 2);
        end
        apb(1'b1, `UFBC_A_DIVLO, 8'h04);
        tick_chk(40, 40);
        apb(1'b1, `UFBC_A_FRAC, 8'h08);
        tick_chk(35, 36);
        apb(1'b1, `UFBC_A_ENH, 8'h10);
        start_rx(8'h5C, 8'h14);
        apb(1'b1, `UFBC_A_EXTRA, 8'h02);
        wait_rx();
        chk(ev[0], 1'b1);
        chk(rx_accept, 1'b0);
        start_rx(8'h5C, 8'h08);
        wait_rx();
        chk(ev[0], 1'b0);
        apb(1'b1, `UFBC_A_EXTRA, 8'h01);
        repeat (2) @(posedge clk);
        chk({rx_accept, nine_bit_mode}, 2'b11);
        apb(1'b1, `UFBC_A_EXTRA, 8'h00);
        for (i = 4; i < 8; i++) apb(1'b1, reg_rows[i][28:17], reg_rows[i][16:9]);
        for (i = 0; i < 11; i++) begin
            if (rx_rows[i][23:16] !== cur) apb(1'b1, `UFBC_A_ENH, 8'h00);
            if (rx_rows[i][23:16] !== cur) apb(1'b1, `UFBC_A_ENH, rx_rows[i][23:16]);
            cur = rx_rows[i][23:16];
            start_rx(rx_rows[i][15:8], 8'h06);
            wait_rx();
            chk(ev & rx_rows[i][7:4], rx_rows[i][3:0]);
        end
        test_done();
    end
endmodule
